// >>> verilog/tbfs_shaper.sv
// Two bucket frame shaper top: arrival decision, periodic refill and drain
// Overview of operation
// R1 - Each tick adds committed_rate/8 to committed bucket, capped at committed_burst; ticks during refill or drain are ignored.
// R2 - Overflow above committed_burst, times coupling_flag, joins excess refill, capped.
// R3 - Committed overflow goes to excess bucket only when coupling_flag is set.
// R4 - Drain head with committed tokens when it fits and green or blind.
// R5 - Otherwise drain with excess tokens when they fit; repeat until neither.
// R6 - Green uses committed then excess tokens; aware yellow uses excess only.
// R7 - color_mode affects release token choice and admission, both limit and forward token choice.
// R8 - Admission uses yellow_limit for aware yellow frames, shaper_limit otherwise.
// R9 - Aware yellow at empty buffer: forward on excess, else enqueue, else drop.
// R10 - Other arrivals at empty buffer: committed, excess, enqueue or drop.
// R11 - Non-empty buffer: never bypass; enqueue under limit checks or drop.
// R12 - Reset fills committed bucket to committed_burst, excess to excess_burst.
// R13 - Arrival decision runs once per frame, immediately, apart from refill.
// R14 - Transfers debit length minus offset; occupancy drops by full length.
// R15 - Occupancy and tokens counted in bytes; rates divided by eight.
// R16 - Frames leave buffer head first-in first-out into transmission queue.
// R17 - Software sets committed_rate nonzero and coupling or excess_rate nonzero.
// R18 - Software should keep shaper_limit minus yellow_limit at least committed_burst.
// R19 - Refill interval is a programmable count of core clock cycles.
// R20 - Arithmetic widths hold maximum bursts and limits without wrap.
`timescale 1ns/100ps
module tbfs_shaper (
  input wire logic ref_clk, // Core clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic newValid, // New frame arrives
  input wire tbfs_pkg::tbfs_frame_s newFrame, // Length and color of arrival
  output logic newReady, // Arrival can be taken
  output logic newDropped, // Arrival discarded, one-cycle pulse
  output logic txValid, // Frame to transmission queue
  output tbfs_pkg::tbfs_frame_s txFrame, // Frame handed downstream
  input wire logic txReady // Transmission queue has room
);
  localparam logic [tbfs_pkg::CNT_W-1:0] ONE_CNT = 32'h0000_0001;

  logic [31:0] committedRate, committedBurst, excessRate, excessBurst;
  logic [31:0] shaperLimit, yellowLimit, tickPeriod, dropCount;
  logic [tbfs_pkg::LEN_W-1:0] tokenOffset;
  logic couplingFlag, colorAware;
  logic [31:0] cTok, eTok, occ;
  logic [31:0] next_cTok, next_eTok, next_occ;
  logic tick;
  tbfs_pkg::tbfs_state_e state, next_state;
  tbfs_pkg::tbfs_frame_s fifoMem [tbfs_pkg::DEPTH];
  logic [tbfs_pkg::PTR_W:0] wrPtr, rdPtr;
  logic [tbfs_pkg::PTR_W:0] fill;
  logic fifoEmpty, fifoFull;
  logic doEnq, doDeq, doFwd, doDrop;
  logic [1:0] fwdPath;
  logic drainUseC, drainUseE;
  tbfs_pkg::tbfs_frame_s head;
  logic [32:0] cSum, eSum;
  logic [31:0] cFill, overflow, eAdd;

  // Tokens a frame needs, floored at zero when offset exceeds length
  function automatic logic [31:0] need(input logic [tbfs_pkg::LEN_W-1:0] len,
                                       input logic [tbfs_pkg::LEN_W-1:0] off);
    need = (len > off) ? {16'h0000, len - off} : tbfs_pkg::ZERO_CNT;
  endfunction

  function automatic logic isAwareYellow(input tbfs_pkg::tbfs_frame_s f, input logic aware);
    isAwareYellow = f.yellow && aware;
  endfunction

  tbfs_tick_gen u_tick (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .period(tickPeriod), // R19
    .tick(tick)
  );

  // APB slave, zero wait state
  assign pready = 1'b1;
  logic apbWr, addrOk;
  logic [31:0] rdMux;
  assign apbWr = psel && penable && pwrite;
  always_comb begin
    addrOk = 1'b1;
    case (paddr)
      tbfs_pkg::OFF_CRATE: rdMux = committedRate;
      tbfs_pkg::OFF_CBURST: rdMux = committedBurst;
      tbfs_pkg::OFF_ERATE: rdMux = excessRate;
      tbfs_pkg::OFF_EBURST: rdMux = excessBurst;
      tbfs_pkg::OFF_CTRL: rdMux = {30'h0000_0000, colorAware, couplingFlag};
      tbfs_pkg::OFF_SLIMIT: rdMux = shaperLimit;
      tbfs_pkg::OFF_YLIMIT: rdMux = yellowLimit;
      tbfs_pkg::OFF_OFFSET: rdMux = {16'h0000, tokenOffset};
      tbfs_pkg::OFF_TICKCNT: rdMux = tickPeriod;
      tbfs_pkg::OFF_CTOK: rdMux = cTok;
      tbfs_pkg::OFF_ETOK: rdMux = eTok;
      tbfs_pkg::OFF_OCC: rdMux = occ;
      tbfs_pkg::OFF_DROPS: rdMux = dropCount;
      default: begin
        rdMux = tbfs_pkg::ZERO_CNT;
        addrOk = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !addrOk;
  // Read data latched in setup; counters read as they stood one cycle early
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= tbfs_pkg::ZERO_CNT;
    end else if (psel && !penable) begin
      prdata <= rdMux;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      committedRate <= tbfs_pkg::RST_CRATE;
      committedBurst <= tbfs_pkg::RST_CBURST;
      excessRate <= tbfs_pkg::RST_ERATE;
      excessBurst <= tbfs_pkg::RST_EBURST;
      shaperLimit <= tbfs_pkg::RST_SLIMIT;
      yellowLimit <= tbfs_pkg::RST_YLIMIT;
      tickPeriod <= tbfs_pkg::RST_TICKCNT;
      tokenOffset <= 16'h0000;
      couplingFlag <= 1'b0;
      colorAware <= 1'b0;
    end else if (apbWr) begin
      case (paddr)
        tbfs_pkg::OFF_CRATE: committedRate <= pwdata;
        tbfs_pkg::OFF_CBURST: committedBurst <= pwdata;
        tbfs_pkg::OFF_ERATE: excessRate <= pwdata;
        tbfs_pkg::OFF_EBURST: excessBurst <= pwdata;
        tbfs_pkg::OFF_CTRL: begin
          couplingFlag <= pwdata[tbfs_pkg::CTRL_CF_BIT];
          colorAware <= pwdata[tbfs_pkg::CTRL_CM_BIT];
        end
        tbfs_pkg::OFF_SLIMIT: shaperLimit <= pwdata;
        tbfs_pkg::OFF_YLIMIT: yellowLimit <= pwdata;
        tbfs_pkg::OFF_OFFSET: tokenOffset <= pwdata[tbfs_pkg::LEN_W-1:0];
        tbfs_pkg::OFF_TICKCNT: tickPeriod <= pwdata;
        default: ;
      endcase
    end
  end

  // Shaper buffer, frame descriptors only
  assign fill = wrPtr - rdPtr;
  assign fifoEmpty = (wrPtr == rdPtr);
  assign fifoFull = fill[tbfs_pkg::PTR_W];
  assign head = fifoMem[rdPtr[tbfs_pkg::PTR_W-1:0]];
  always_ff @(posedge ref_clk) begin
    if (doEnq) begin
      fifoMem[wrPtr[tbfs_pkg::PTR_W-1:0]] <= newFrame;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doEnq) begin
        wrPtr <= wrPtr + 7'h01;
      end
      if (doDeq) begin
        rdPtr <= rdPtr + 7'h01; // R16
      end
    end
  end

  // Refill arithmetic, 33 bits so sums never wrap
  assign cSum = {1'b0, cTok} + {1'b0, committedRate / tbfs_pkg::BITS_PER_BYTE}; // R15 R20
  assign cFill = (cSum > {1'b0, committedBurst}) ? committedBurst : cSum[31:0]; // R1
  assign overflow = (cSum > {1'b0, committedBurst}) ?
                    32'(cSum - {1'b0, committedBurst}) : tbfs_pkg::ZERO_CNT; // R2
  assign eAdd = couplingFlag ? overflow : tbfs_pkg::ZERO_CNT; // R3
  assign eSum = {1'b0, eTok} + {1'b0, excessRate / tbfs_pkg::BITS_PER_BYTE} + {1'b0, eAdd};

  // Drain eligibility for the head frame
  assign drainUseC = !fifoEmpty && (need(head.len, tokenOffset) <= cTok) &&
                     (!head.yellow || !colorAware); // R4 R6
  assign drainUseE = !fifoEmpty && !drainUseC &&
                     (need(head.len, tokenOffset) <= eTok); // R5 R6

  // Arrival decision; holds off during refill and drain, while any frame is pending downstream, or while the buffer is full
  logic emptyNow, ayNew, fitsQ;
  logic [32:0] occPlus;
  assign emptyNow = fifoEmpty && (occ == tbfs_pkg::ZERO_CNT);
  assign ayNew = isAwareYellow(newFrame, colorAware); // R7
  assign occPlus = {1'b0, occ} + {17'h0_0000, newFrame.len};
  always_comb begin
    fitsQ = 1'b0;
    if (ayNew) begin
      fitsQ = (occPlus <= {1'b0, yellowLimit}) &&
              (need(newFrame.len, tokenOffset) <= excessBurst); // R8
    end else begin
      fitsQ = (occPlus <= {1'b0, shaperLimit}) &&
              (need(newFrame.len, tokenOffset) <=
               ((committedBurst > excessBurst) ? committedBurst : excessBurst)); // R8
    end
  end
  assign newReady = (state == tbfs_pkg::TBFS_IDLE) && !txValid && !fifoFull;
  always_comb begin
    fwdPath = 2'b00;
    doEnq = 1'b0;
    doDrop = 1'b0;
    if (newValid && newReady) begin // R13
      if (emptyNow && ayNew && need(newFrame.len, tokenOffset) <= eTok) begin
        fwdPath = 2'b10; // R9
      end else if (emptyNow && !ayNew && need(newFrame.len, tokenOffset) <= cTok) begin
        fwdPath = 2'b01; // R10
      end else if (emptyNow && !ayNew && need(newFrame.len, tokenOffset) <= eTok) begin
        fwdPath = 2'b10; // R10
      end else if (fitsQ) begin
        doEnq = 1'b1; // R9 R10 R11
      end else begin
        doDrop = 1'b1;
      end
    end
  end
  assign doFwd = fwdPath != 2'b00;
  assign doDeq = (state == tbfs_pkg::TBFS_DRAIN) && !txValid && (drainUseC || drainUseE);

  // Refill then drain loop per tick
  always_comb begin
    next_state = state;
    case (state)
      tbfs_pkg::TBFS_IDLE: if (tick) next_state = tbfs_pkg::TBFS_REFILL;
      tbfs_pkg::TBFS_REFILL: next_state = tbfs_pkg::TBFS_DRAIN;
      tbfs_pkg::TBFS_DRAIN: begin
        if (!txValid && !drainUseC && !drainUseE) next_state = tbfs_pkg::TBFS_IDLE; // R5
      end
      default: next_state = tbfs_pkg::TBFS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= tbfs_pkg::TBFS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Token and occupancy update
  always_comb begin
    next_cTok = cTok;
    next_eTok = eTok;
    next_occ = occ;
    if (state == tbfs_pkg::TBFS_REFILL) begin
      next_cTok = cFill; // R1
      next_eTok = (eSum > {1'b0, excessBurst}) ? excessBurst : eSum[31:0]; // R2
    end
    if (doDeq && drainUseC) begin
      next_cTok = cTok - need(head.len, tokenOffset); // R4 R14
    end
    if (doDeq && drainUseE) begin
      next_eTok = eTok - need(head.len, tokenOffset); // R5 R14
    end
    if (doDeq) begin
      next_occ = occ - {16'h0000, head.len}; // R14
    end
    if (fwdPath == 2'b01) begin
      next_cTok = cTok - need(newFrame.len, tokenOffset); // R14
    end
    if (fwdPath == 2'b10) begin
      next_eTok = eTok - need(newFrame.len, tokenOffset); // R14
    end
    if (doEnq) begin
      next_occ = occPlus[31:0]; // R11
    end
  end
  // Buckets start full; burst registers are at their reset values then
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cTok <= tbfs_pkg::RST_CBURST; // R12
      eTok <= tbfs_pkg::RST_EBURST; // R12
      occ <= tbfs_pkg::ZERO_CNT;
    end else begin
      cTok <= next_cTok;
      eTok <= next_eTok;
      occ <= next_occ;
    end
  end

  // Output register toward transmission queue
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txValid <= 1'b0;
      txFrame <= '0;
    end else if (txValid && !txReady) begin
      txValid <= 1'b1;
    end else if (doDeq) begin
      txValid <= 1'b1;
      txFrame <= head; // R16
    end else if (doFwd) begin
      txValid <= 1'b1;
      txFrame <= newFrame;
    end else begin
      txValid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      newDropped <= 1'b0;
      dropCount <= tbfs_pkg::ZERO_CNT;
    end else begin
      newDropped <= doDrop;
      if (doDrop) begin
        dropCount <= dropCount + ONE_CNT;
      end
    end
  end
endmodule

// >>> pkg/tbfs_pkg.sv
// Package for the two bucket frame shaper: widths, register map, carriers
package tbfs_pkg;
  localparam int CNT_W = 32;
  localparam int LEN_W = 16;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam logic [CNT_W-1:0] BITS_PER_BYTE = 32'h0000_0008;
  localparam logic [CNT_W-1:0] ZERO_CNT = 32'h0000_0000;
  localparam logic [11:0] OFF_CRATE = 12'h000;
  localparam logic [11:0] OFF_CBURST = 12'h004;
  localparam logic [11:0] OFF_ERATE = 12'h008;
  localparam logic [11:0] OFF_EBURST = 12'h00C;
  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_SLIMIT = 12'h014;
  localparam logic [11:0] OFF_YLIMIT = 12'h018;
  localparam logic [11:0] OFF_OFFSET = 12'h01C;
  localparam logic [11:0] OFF_TICKCNT = 12'h020;
  localparam logic [11:0] OFF_CTOK = 12'h024;
  localparam logic [11:0] OFF_ETOK = 12'h028;
  localparam logic [11:0] OFF_OCC = 12'h02C;
  localparam logic [11:0] OFF_DROPS = 12'h030;
  localparam int CTRL_CF_BIT = 0;
  localparam int CTRL_CM_BIT = 1;
  localparam logic [CNT_W-1:0] RST_CRATE = 32'h0000_0800;
  localparam logic [CNT_W-1:0] RST_CBURST = 32'h0000_2000;
  localparam logic [CNT_W-1:0] RST_ERATE = 32'h0000_0800;
  localparam logic [CNT_W-1:0] RST_EBURST = 32'h0000_2000;
  localparam logic [CNT_W-1:0] RST_SLIMIT = 32'h0000_8000;
  localparam logic [CNT_W-1:0] RST_YLIMIT = 32'h0000_4000;
  localparam logic [CNT_W-1:0] RST_TICKCNT = 32'h0000_0064;
  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic yellow;
  } tbfs_frame_s;
  typedef enum logic [1:0] {
    TBFS_IDLE = 2'b00,
    TBFS_REFILL = 2'b01,
    TBFS_DRAIN = 2'b10
  } tbfs_state_e;
endpackage

// >>> verilog/tbfs_tick_gen.sv
// Refill interval tick generator
`timescale 1ns/100ps
module tbfs_tick_gen (
  input wire logic ref_clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic [tbfs_pkg::CNT_W-1:0] period, // Interval in clock cycles
  output logic tick // One-cycle pulse per interval
);
  logic [tbfs_pkg::CNT_W-1:0] count;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= tbfs_pkg::ZERO_CNT;
      tick <= 1'b0;
    end else if (count + 32'h0000_0001 >= period) begin
      count <= tbfs_pkg::ZERO_CNT;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

// >>> test/tbfs_shaper_assertions.sv
// Port-level checks of the frame shaper
`timescale 1ns/100ps
module tbfs_shaper_assertions (
  input wire logic ref_clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic newValid, // Arrival offered
  input wire logic newReady, // Arrival taken
  input wire logic newDropped, // Discard pulse
  input wire logic txValid, // Frame downstream
  input wire tbfs_pkg::tbfs_frame_s txFrame, // Downstream frame
  input wire logic txReady // Queue has room
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic acc = psel && penable;
  AST_ZERO_WAIT: assert property (acc |-> pready)
    else $error("apb access stalled");
  AST_UNMAPPED: assert property (acc && paddr > tbfs_pkg::OFF_DROPS |->
    pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && paddr == tbfs_pkg::OFF_OCC |-> !pslverr)
    else $error("mapped access refused");
  AST_DROP_PULSE: assert property (newDropped |=> !newDropped)
    else $error("discard pulse too long");
  AST_DROP_CAUSE: assert property (newDropped |-> $past(newValid && newReady))
    else $error("discard without arrival");
  AST_DROP_NO_FWD: assert property (newDropped |-> !$rose(txValid))
    else $error("discarded frame also forwarded");
  AST_TX_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txFrame))
    else $error("downstream frame not held");
  AST_ONE_AT_A_TIME: assert property (txValid |-> !newReady)
    else $error("arrival taken while frame pending");
  AST_RESET_IDLE: assert property ($rose(resetn) |-> !txValid && !newDropped)
    else $error("outputs busy after reset");
  cover property (newDropped);
  cover property (txValid && !txReady);
  cover property (acc && pslverr);
endmodule

bind tbfs_shaper tbfs_shaper_assertions i_tbfs_shaper_assertions (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .newValid(newValid), .newReady(newReady), .newDropped(newDropped),
  .txValid(txValid), .txFrame(txFrame), .txReady(txReady));

// >>> test/tbfs_txq_model.sv
// Transmission queue model draining frames toward the link
`timescale 1ns/100ps
module tbfs_txq_model (
  input wire logic ref_clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic txValid, // Frame offered
  input wire tbfs_pkg::tbfs_frame_s txFrame, // Frame offered
  input wire logic stall, // Extra back-pressure
  output logic txReady // Room for one frame
);
  logic [3:0] busy;
  // Link serialises each frame, so room returns after a length-based wait
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 4'h0;
    end else if (txValid && txReady) begin
      busy <= txFrame.len[3:0];
    end else if (busy != 4'h0) begin
      busy <= busy - 4'h1;
    end
  end
  assign txReady = (busy == 4'h0) && !stall;
endmodule

// >>> test/tb.sv
// Self-checking bench for the frame shaper
`timescale 1ns/100ps
module tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic newValid = 1'b0;
  tbfs_pkg::tbfs_frame_s newFrame = '0;
  logic newReady;
  logic newDropped;
  logic txValid;
  tbfs_pkg::tbfs_frame_s txFrame;
  logic txReady;
  logic stall = 1'b0;
  logic [31:0] rnd;
  logic [31:0] rdat;
  logic rerr;
  logic [17:0] note;
  logic [31:0] got;
  integer seed = 604;
  int n_fail = 0;
  int checked = 0;
  logic [17:0] expq[$];
  tbfs_shaper i_tbfs_shaper (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .newValid(newValid), .newFrame(newFrame),
    .newReady(newReady), .newDropped(newDropped), .txValid(txValid), .txFrame(txFrame),
    .txReady(txReady));
  tbfs_txq_model i_tbfs_txq_model (.ref_clk(ref_clk), .resetn(resetn), .txValid(txValid),
    .txFrame(txFrame), .stall(stall), .txReady(txReady));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rnd = $random(seed);
    stall <= (rnd[1:0] == 2'h0);
  end
  task automatic end_of_test();
    $display("Counts: %0d compared, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    end_of_test();
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(what, exp, rdat);
  endtask
  // Kind: 0 kept in buffer, 1 forwarded, 2 discarded
  task automatic send(input logic [15:0] len, input logic yel, input logic [1:0] kind);
    int k;
    @(posedge ref_clk);
    if (kind != 2'h0) expq.push_back({kind == 2'h1, len, yel});
    newFrame <= '{len: len, yellow: yel};
    newValid <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (newReady !== 1'b1 && k < 200);
    if (k >= 200) hang();
    newValid <= 1'b0;
  endtask
  // Discards carry no frame, so only their kind is compared
  always @(posedge ref_clk) begin
    if (resetn && ((txValid === 1'b1 && txReady === 1'b1) || newDropped === 1'b1)) begin
      if (expq.size() == 0) begin
        check("unexpected output", 32'h0000_0000, 32'h0000_0001);
      end else begin
        note = expq.pop_front();
        got = newDropped ? {14'h0000, 1'b0, note[16:0]} : {14'h0000, 1'b1, txFrame};
        check("output frame", {14'h0000, note}, got);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    hang();
  end
  initial begin
    int k;
    logic [31:0] v;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rd("committed at reset", tbfs_pkg::OFF_CTOK, 32'h0000_2000);
    rd("excess at reset", tbfs_pkg::OFF_ETOK, 32'h0000_2000);
    rd("unmapped read", 12'h040, 32'h0000_0000);
    check("unmapped error", 32'h0000_0001, {31'h0000_0000, rerr});
    // Ticks parked instead of zero rates, so token counts stay exact
    apb(1'b1, tbfs_pkg::OFF_TICKCNT, 32'hFFFF_FFFF);
    rd("shaper limit", tbfs_pkg::OFF_SLIMIT, 32'h0000_8000);
    apb(1'b1, tbfs_pkg::OFF_OFFSET, 32'h0000_0004);
    apb(1'b1, tbfs_pkg::OFF_CTRL, 32'h0000_0002);
    $display("Test reset and registers done");
    send(16'h1000, 1'b0, 2'h1);
    rd("committed after green", tbfs_pkg::OFF_CTOK, 32'h0000_1004);
    send(16'h0800, 1'b1, 2'h1);
    rd("excess after yellow", tbfs_pkg::OFF_ETOK, 32'h0000_1804);
    send(16'h1800, 1'b0, 2'h1);
    send(16'h1000, 1'b0, 2'h1);
    send(16'h0100, 1'b0, 2'h0);
    send(16'h0100, 1'b1, 2'h0);
    send(16'h9000, 1'b0, 2'h2);
    send(16'h3F00, 1'b1, 2'h2);
    rd("occupancy", tbfs_pkg::OFF_OCC, 32'h0000_0200);
    rd("discards", tbfs_pkg::OFF_DROPS, 32'h0000_0002);
    $display("Test arrival decisions done");
    expq.push_back({1'b1, 16'h0100, 1'b0});
    expq.push_back({1'b1, 16'h0100, 1'b1});
    apb(1'b1, tbfs_pkg::OFF_TICKCNT, 32'h0000_000A);
    apb(1'b1, tbfs_pkg::OFF_CRATE, 32'h0000_0800);
    apb(1'b1, tbfs_pkg::OFF_ERATE, 32'h0000_0800);
    k = 0;
    while (expq.size() != 0 && k < 500) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 500) hang();
    rd("occupancy drained", tbfs_pkg::OFF_OCC, 32'h0000_0000);
    $display("Test periodic drain done");
    apb(1'b1, tbfs_pkg::OFF_ERATE, 32'h0000_0000);
    apb(1'b0, tbfs_pkg::OFF_ETOK, 32'h0000_0000);
    v = rdat;
    repeat (500) @(posedge ref_clk);
    rd("excess uncoupled", tbfs_pkg::OFF_ETOK, v);
    rd("committed saturated", tbfs_pkg::OFF_CTOK, 32'h0000_2000);
    apb(1'b1, tbfs_pkg::OFF_CTRL, 32'h0000_0003);
    repeat (1000) @(posedge ref_clk);
    rd("excess coupled", tbfs_pkg::OFF_ETOK, 32'h0000_2000);
    $display("Test refill and coupling done");
    apb(1'b1, tbfs_pkg::OFF_TICKCNT, 32'hFFFF_FFFF);
    apb(1'b1, tbfs_pkg::OFF_CTRL, 32'h0000_0001);
    send(16'h1004, 1'b1, 2'h1);
    rd("committed after blind yellow", tbfs_pkg::OFF_CTOK, 32'h0000_1000);
    $display("Test color blind done");
    end_of_test();
  end
endmodule
